// ---- hw/acc_pkg.sv ----
package acc_pkg;
    // Register word addresses (byte address = 4 * index)
    localparam logic [3:0] ACC_IDX_CTRL1 = 4'h0;
    localparam logic [3:0] ACC_IDX_CTRL2 = 4'h1;
    localparam logic [3:0] ACC_IDX_CTRL3 = 4'h2;
    localparam logic [3:0] ACC_IDX_RES_HI = 4'h3;
    localparam logic [3:0] ACC_IDX_RES_LO = 4'h4;
    localparam logic [3:0] ACC_IDX_DMA_ADR = 4'h5;
    localparam logic [3:0] ACC_IDX_STATUS = 4'h6;
    // Control one fields
    localparam int ACC_C1_POWER = 7;
    localparam int ACC_C1_EXTREF = 6;
    localparam int ACC_C1_DIV_HI = 5;
    localparam int ACC_C1_DIV_LO = 4;
    localparam int ACC_C1_ACQ_LSB = 2;
    localparam int ACC_C1_T2_EN = 1;
    localparam int ACC_C1_PIN_EN = 0;
    localparam logic [7:0] ACC_C1_RESET = 8'h40;
    // Control two fields
    localparam int ACC_C2_DMA = 7;
    localparam int ACC_C2_CONT = 5;
    localparam int ACC_C2_SINGLE = 4;
    localparam logic [7:0] ACC_C2_RESET = 8'h00;
    // Control three fields
    localparam int ACC_C3_CAL = 0;
    localparam logic [7:0] ACC_C3_RESET = 8'h00;
    // Timing, widths and sizes
    localparam int ACC_CONV_CLKS = 16;
    localparam int ACC_DIV_W = 5;
    localparam int ACC_CODES = 4096;
    localparam int ACC_CHAN_TEMP = 8;
    localparam int ACC_DMA_AW = 24;

    typedef struct packed {
        logic [3:0] chan;
        logic [11:0] code;
    } acc_sample_s;

    typedef enum logic [1:0] {
        ACC_DIV32,
        ACC_DIV4,
        ACC_DIV8,
        ACC_DIV2
    } acc_div_e;
endpackage : acc_pkg

// ---- hw/acc_fifo.sv ----
`timescale 1ns/1ps
module acc_fifo #(
    parameter int WIDTH = 40,
    parameter int DEPTH = 4
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_shape
        $error("acc_fifo: WIDTH >= 1 and DEPTH a power of two >= 2 needed");
    end
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW:0] wr_reg;
    logic [AW:0] rd_reg;
    logic push;
    logic pop;
    assign in_ready = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
    assign out_valid = wr_reg != rd_reg;
    assign out_data = mem_reg[rd_reg[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always_ff @(posedge mclk) begin
        if (push) begin
            mem_reg[wr_reg[AW-1:0]] <= in_data;
        end
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            if (push) wr_reg <= wr_reg + 1'b1;
            if (pop) rd_reg <= rd_reg + 1'b1;
        end
    end
endmodule : acc_fifo

// ---- hw/acc_conv_ctrl.sv ----
`timescale 1ns/1ps
// Contract
// - Twelve-bit straight binary code, step FS/4096.
// - Result into high/low, channel in top nibble.
// - Single and continuous, software or pin start.
// - Timer two overflow starts conversions.
// - DMA converts continuously into 24-bit address space.
// - Factory calibration loads at power-up automatically.
// - Offset and gain calibration registers held.
// - Eight channels plus temperature as ninth.
// - Power bit powers converter up or down.
// - Divide bits select 32, 4, 8, 2.
// - Conversion takes sixteen clocks plus acquisition.
module acc_conv_ctrl #(
    parameter logic [7:0] FACT_OFFSET = 8'h80,
    parameter logic [7:0] FACT_GAIN = 8'h80,
    parameter int FIFO_DEPTH = 4
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic conv_pin,
    input wire logic timer2_ovf,
    output logic conv_power_on,
    output logic ext_ref_sel,
    output logic [3:0] mux_sel,
    output logic sample_hold,
    output logic sar_clk_en,
    input wire logic [11:0] sar_code,
    input wire logic sar_done,
    output logic [7:0] cal_offset,
    output logic [7:0] cal_gain,
    output logic [23:0] dma_addr,
    output logic [15:0] dma_wdata,
    output logic dma_write,
    input wire logic dma_waitrequest
);
    import acc_pkg::*;
    if (FIFO_DEPTH < 2) begin : g_bad_depth
        $error("acc_conv_ctrl: FIFO_DEPTH too small");
    end

    typedef enum logic [1:0] {ACC_IDLE, ACC_ACQ, ACC_CONV, ACC_STORE} acc_state_e;

    logic rst_s1_reg;
    logic rst_sync_n;
    logic [7:0] ctrl1_reg;
    logic [7:0] ctrl2_reg;
    logic [7:0] ctrl3_reg;
    acc_sample_s result_reg;
    logic [23:0] dma_ptr_reg;
    logic [7:0] off_reg;
    logic [7:0] gain_reg;
    logic cal_loaded_reg;
    logic overrun_reg;
    acc_state_e state_reg;
    logic [ACC_DIV_W-1:0] div_cnt_reg;
    logic [ACC_DIV_W-1:0] div_max;
    logic tick;
    logic [4:0] bit_cnt_reg;
    logic [4:0] acq_len;
    logic pin_d_reg;
    logic start_req;
    logic running;
    logic [31:0] rdata_next;
    logic fifo_in_ready;
    logic fifo_out_valid;
    acc_sample_s fifo_out;
    logic wr_hit;
    logic [11:0] code_tmp;

    // Reset release through two stages
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_reg <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_sync_n <= rst_s1_reg;
        end
    end

    // Bus: every access stalls one cycle so waitrequest comes from a flop
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
        end
    end
    assign wr_hit = avs_write && !avs_waitrequest;

    always_comb begin
        rdata_next = 32'h0000_0000;
        unique case (avs_address[5:2])
            ACC_IDX_CTRL1: rdata_next = {24'h00_0000, ctrl1_reg};
            ACC_IDX_CTRL2: rdata_next = {24'h00_0000, ctrl2_reg};
            ACC_IDX_CTRL3: rdata_next = {8'h00, gain_reg, off_reg, ctrl3_reg};
            ACC_IDX_RES_HI: rdata_next = {24'h00_0000, result_reg.chan, result_reg.code[11:8]};
            ACC_IDX_RES_LO: rdata_next = {24'h00_0000, result_reg.code[7:0]};
            ACC_IDX_DMA_ADR: rdata_next = {8'h00, dma_ptr_reg};
            ACC_IDX_STATUS: rdata_next = {28'h000_0000, overrun_reg, cal_loaded_reg,
                                          running, state_reg != ACC_IDLE};
            default: rdata_next = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= rdata_next;
        end
    end

    // Three control registers; single-shot bit self-clears on start
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ctrl1_reg <= ACC_C1_RESET;
            ctrl2_reg <= ACC_C2_RESET;
            ctrl3_reg <= ACC_C3_RESET;
        end else begin
            if (wr_hit && avs_address[5:2] == ACC_IDX_CTRL1) ctrl1_reg <= avs_writedata[7:0];
            if (wr_hit && avs_address[5:2] == ACC_IDX_CTRL2) begin
                ctrl2_reg <= avs_writedata[7:0];
            end else if (state_reg == ACC_IDLE && start_req && ctrl1_reg[ACC_C1_POWER]) begin
                ctrl2_reg[ACC_C2_SINGLE] <= 1'b0;
            end
            if (wr_hit && avs_address[5:2] == ACC_IDX_CTRL3) begin
                ctrl3_reg <= avs_writedata[7:0];
            end else if (state_reg == ACC_STORE) begin
                ctrl3_reg[ACC_C3_CAL] <= 1'b0;
            end
        end
    end

    // Calibration: factory values load after reset, optional hardware update
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            off_reg <= 8'h00;
            gain_reg <= 8'h00;
            cal_loaded_reg <= 1'b0;
        end else if (!cal_loaded_reg) begin
            off_reg <= FACT_OFFSET;
            gain_reg <= FACT_GAIN;
            cal_loaded_reg <= 1'b1;
        end else if (wr_hit && avs_address[5:2] == ACC_IDX_CTRL3) begin
            off_reg <= avs_writedata[15:8];
            gain_reg <= avs_writedata[23:16];
        end else if (state_reg == ACC_STORE && ctrl3_reg[ACC_C3_CAL]) begin
            // Hardware offset trim: null a grounded reading toward code zero
            off_reg <= off_reg + sar_code[7:0];
        end
    end

    // Converter clock divider
    always_comb begin
        unique case (acc_div_e'({ctrl1_reg[ACC_C1_DIV_HI], ctrl1_reg[ACC_C1_DIV_LO]}))
            ACC_DIV32: div_max = 5'h1F;
            ACC_DIV4: div_max = 5'h03;
            ACC_DIV8: div_max = 5'h07;
            ACC_DIV2: div_max = 5'h01;
        endcase
    end
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            div_cnt_reg <= '0;
        end else if (!ctrl1_reg[ACC_C1_POWER] || div_cnt_reg >= div_max) begin
            div_cnt_reg <= '0;
        end else begin
            div_cnt_reg <= div_cnt_reg + 1'b1;
        end
    end
    assign tick = ctrl1_reg[ACC_C1_POWER] && div_cnt_reg >= div_max;
    assign acq_len = 5'(1) << ctrl1_reg[ACC_C1_ACQ_LSB +: 2];

    // Start sources
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pin_d_reg <= 1'b0;
        end else begin
            pin_d_reg <= conv_pin;
        end
    end
    assign start_req = ctrl2_reg[ACC_C2_SINGLE] || ctrl2_reg[ACC_C2_CONT]
                    || ctrl2_reg[ACC_C2_DMA]
                    || (ctrl1_reg[ACC_C1_PIN_EN] && conv_pin && !pin_d_reg)
                    || (ctrl1_reg[ACC_C1_T2_EN] && timer2_ovf);
    assign running = ctrl2_reg[ACC_C2_CONT] || ctrl2_reg[ACC_C2_DMA];

    // Conversion sequencer
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_reg <= ACC_IDLE;
            bit_cnt_reg <= '0;
        end else if (!ctrl1_reg[ACC_C1_POWER]) begin
            state_reg <= ACC_IDLE;
            bit_cnt_reg <= '0;
        end else begin
            unique case (state_reg)
                ACC_IDLE: if (start_req) begin
                    state_reg <= ACC_ACQ;
                    bit_cnt_reg <= '0;
                end
                ACC_ACQ: if (tick) begin
                    if (bit_cnt_reg + 5'd1 >= acq_len) begin
                        state_reg <= ACC_CONV;
                        bit_cnt_reg <= '0;
                    end else begin
                        bit_cnt_reg <= bit_cnt_reg + 5'd1;
                    end
                end
                ACC_CONV: begin
                    if (bit_cnt_reg == 5'(ACC_CONV_CLKS)) begin
                        // All clocks sent; a slow converter is waited for, never overclocked
                        if (sar_done) begin
                            state_reg <= ACC_STORE;
                        end
                    end else if (tick) begin
                        bit_cnt_reg <= bit_cnt_reg + 5'h01;
                    end
                end
                ACC_STORE: if (!ctrl2_reg[ACC_C2_DMA] || fifo_in_ready) begin
                    state_reg <= ACC_IDLE;
                end
            endcase
        end
    end

    // Result: code and tag land in one edge
    assign code_tmp = sar_code;
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            result_reg <= '0;
            overrun_reg <= 1'b0;
        end else begin
            if (state_reg == ACC_STORE && !ctrl3_reg[ACC_C3_CAL]
                && (!ctrl2_reg[ACC_C2_DMA] || fifo_in_ready)) begin
                result_reg <= '{chan: mux_sel, code: code_tmp};
            end
            if (state_reg == ACC_STORE && ctrl2_reg[ACC_C2_DMA] && !fifo_in_ready) begin
                overrun_reg <= 1'b1;
            end else if (wr_hit && avs_address[5:2] == ACC_IDX_STATUS) begin
                overrun_reg <= 1'b0;
            end
        end
    end

    // Analog-side drive, all registered
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            conv_power_on <= 1'b0;
            ext_ref_sel <= 1'b0;
            mux_sel <= 4'h0;
            sample_hold <= 1'b0;
            sar_clk_en <= 1'b0;
            cal_offset <= 8'h00;
            cal_gain <= 8'h00;
        end else begin
            conv_power_on <= ctrl1_reg[ACC_C1_POWER];
            ext_ref_sel <= ctrl1_reg[ACC_C1_EXTREF];
            if (state_reg == ACC_IDLE) begin
                mux_sel <= ctrl2_reg[3:0] > 4'(ACC_CHAN_TEMP) ? 4'(ACC_CHAN_TEMP) : ctrl2_reg[3:0];
            end
            sample_hold <= state_reg == ACC_ACQ;
            sar_clk_en <= tick && state_reg == ACC_CONV
                          && bit_cnt_reg != 5'(ACC_CONV_CLKS);
            cal_offset <= off_reg;
            cal_gain <= gain_reg;
        end
    end

    // DMA path through the sample FIFO
    acc_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
        .mclk(mclk),
        .rst_n(rst_sync_n),
        .in_data({mux_sel, code_tmp}),
        .in_valid(state_reg == ACC_STORE && ctrl2_reg[ACC_C2_DMA] && !ctrl3_reg[ACC_C3_CAL]),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out),
        .out_valid(fifo_out_valid),
        .out_ready(!dma_write && ctrl2_reg[ACC_C2_DMA])
    );
    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            dma_write <= 1'b0;
            dma_wdata <= 16'h0000;
            dma_addr <= 24'h00_0000;
            dma_ptr_reg <= 24'h00_0000;
        end else begin
            if (dma_write) begin
                if (!dma_waitrequest) begin
                    dma_write <= 1'b0;
                    dma_ptr_reg <= dma_ptr_reg + 24'h00_0002;
                end
            end else if (fifo_out_valid && ctrl2_reg[ACC_C2_DMA]) begin
                dma_write <= 1'b1;
                dma_wdata <= fifo_out;
                dma_addr <= dma_ptr_reg;
            end
            // Pointer write must not swallow a popped sample or a finished write
            if (wr_hit && avs_address[5:2] == ACC_IDX_DMA_ADR) begin
                dma_ptr_reg <= avs_writedata[23:0];
            end
        end
    end
endmodule : acc_conv_ctrl

// ---- sim/acc_sar_model.sv ----
`timescale 1ns/1ps
module acc_sar_model (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic sample_hold,
    input wire logic sar_clk_en,
    input wire logic [11:0] level,
    input wire logic [2:0] slow,
    output logic [11:0] sar_code,
    output logic sar_done
);
    logic [4:0] cnt_reg;
    logic [2:0] wait_reg;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 5'h00;
            wait_reg <= 3'h0;
        end else if (sample_hold) begin
            cnt_reg <= 5'h00;
            wait_reg <= 3'h0;
        end else begin
            cnt_reg <= cnt_reg + {4'h0, sar_clk_en};
            wait_reg <= wait_reg + {2'h0, cnt_reg >= 5'h0F && wait_reg < slow};
        end
    end
    // Slow answer holds the last bit decision back
    assign sar_done = cnt_reg >= 5'h0F && wait_reg >= slow;
    // Stale code shows inverted so it never matches
    assign sar_code = sar_done ? level : ~level;
endmodule : acc_sar_model

// ---- sim/acc_conv_ctrl_sva.sv ----
`timescale 1ns/1ps
module acc_conv_ctrl_sva #(
    parameter logic [7:0] FACT_OFFSET = 8'h80,
    parameter logic [7:0] FACT_GAIN = 8'h80
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic avs_waitrequest,
    input wire logic conv_power_on,
    input wire logic [3:0] mux_sel,
    input wire logic sample_hold,
    input wire logic sar_clk_en,
    input wire logic [7:0] cal_offset,
    input wire logic [7:0] cal_gain,
    input wire logic [23:0] dma_addr,
    input wire logic dma_write,
    input wire logic dma_waitrequest
);
    logic [7:0] c1_reg;
    logic [5:0] gap_reg, dv;
    logic [4:0] cnt_reg;
    logic hold_reg, c1_wr;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    assign c1_wr = avs_write && !avs_waitrequest && avs_address == 6'h00;
    assign dv = c1_reg[5] ? (c1_reg[4] ? 6'h02 : 6'h08) : (c1_reg[4] ? 6'h04 : 6'h20);
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            c1_reg <= 8'h40;
            gap_reg <= 6'h3F;
            cnt_reg <= 5'h00;
            hold_reg <= 1'b0;
        end else begin
            c1_reg <= c1_wr ? avs_writedata[7:0] : c1_reg;
            // Saturates so idle gaps never pass for a divider value
            gap_reg <= sar_clk_en ? 6'h01 : gap_reg + {5'h00, gap_reg != 6'h3F};
            cnt_reg <= sample_hold ? 5'h00 : cnt_reg + {4'h0, sar_clk_en};
            hold_reg <= sample_hold || (hold_reg && !sar_clk_en);
        end
    end
    property p_wait; $rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest; endproperty
    a_wait: assert property (p_wait) else $error("read wait wrong");
    property p_wr; $rose(avs_write) |-> avs_waitrequest ##1 !avs_waitrequest; endproperty
    a_wr: assert property (p_wr) else $error("write stalled");
    property p_pow; c1_wr ##1 !c1_wr |-> ##1 conv_power_on == c1_reg[7]; endproperty
    a_pow: assert property (p_pow) else $error("power level wrong");
    property p_div; sar_clk_en && !hold_reg && gap_reg < 6'h28 |-> gap_reg == dv; endproperty
    a_div: assert property (p_div) else $error("clock divide wrong");
    property p_max; sar_clk_en |-> cnt_reg < 5'h10; endproperty
    a_max: assert property (p_max) else $error("too many clocks");
    property p_seq; $rose(sample_hold) |-> cnt_reg == 5'h00 || cnt_reg == 5'h10; endproperty
    a_seq: assert property (p_seq) else $error("start mid conversion");
    property p_hold; dma_write && dma_waitrequest |=> dma_write && $stable(dma_addr); endproperty
    a_hold: assert property (p_hold) else $error("dma write dropped");
    property p_cal; $rose(rst_n) |-> ##[1:4] cal_offset == FACT_OFFSET && cal_gain == FACT_GAIN;
    endproperty
    a_cal: assert property (p_cal) else $error("factory cal not loaded");
    property p_mux; sample_hold |-> mux_sel <= 4'h8; endproperty
    a_mux: assert property (p_mux) else $error("channel out of range");
    c_conv: cover property ($rose(sample_hold));
    c_stall: cover property ((dma_write && dma_waitrequest) [*3]);
    c_dma: cover property (dma_write && !dma_waitrequest);
endmodule : acc_conv_ctrl_sva

bind acc_conv_ctrl acc_conv_ctrl_sva #(.FACT_OFFSET(FACT_OFFSET), .FACT_GAIN(FACT_GAIN)) u_sva (
    .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
    .conv_power_on(conv_power_on), .mux_sel(mux_sel), .sample_hold(sample_hold),
    .sar_clk_en(sar_clk_en), .cal_offset(cal_offset), .cal_gain(cal_gain),
    .dma_addr(dma_addr), .dma_write(dma_write), .dma_waitrequest(dma_waitrequest));

// ---- sim/acc_conv_ctrl_tb.sv ----
`timescale 1ns/1ps
module acc_conv_ctrl_tb;
    import acc_pkg::*;
    localparam int LIMIT = 60000;
    logic mclk, rst_n, avs_read, avs_write, avs_waitrequest, conv_pin, timer2_ovf, stall;
    logic conv_power_on, sample_hold, sar_clk_en, sar_done, dma_write, dma_waitrequest;
    logic ext_ref_sel;
    logic [5:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [3:0] mux_sel;
    logic [11:0] sar_code, level;
    logic [2:0] slow;
    logic [7:0] cal_offset, cal_gain;
    logic [23:0] dma_addr;
    logic [15:0] dma_wdata;
    logic [39:0] seen[$];
    int errors, comparisons, cycles, seed;
    acc_conv_ctrl dut (.mclk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .conv_pin, .timer2_ovf, .conv_power_on, .ext_ref_sel,
        .mux_sel, .sample_hold, .sar_clk_en, .sar_code, .sar_done, .cal_offset, .cal_gain,
        .dma_addr, .dma_wdata, .dma_write, .dma_waitrequest);
    acc_sar_model u_sar (.mclk, .rst_n, .sample_hold, .sar_clk_en, .level, .slow, .sar_code,
        .sar_done);
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // Memory side of the DMA port stalls at random
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (dma_write === 1'b1 && dma_waitrequest === 1'b0) seen.push_back({dma_addr, dma_wdata});
        dma_waitrequest <= stall || $random(seed) % 3 == 0;
        if (cycles == LIMIT) begin
            errors++;
            conclude();
        end
    end
    function automatic logic [39:0] hi_exp(input int ch, input logic [11:0] c);
        return {28'h0, (ch > ACC_CHAN_TEMP ? 4'(ACC_CHAN_TEMP) : 4'(ch)), c[11:8]};
    endfunction : hi_exp
    task automatic chk(input logic [39:0] s, input logic [39:0] e);
        comparisons++;
        if (s !== e) begin
            errors++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rc(input logic [5:0] a, input logic [39:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rc
    task automatic idle();
        repeat (8) @(posedge mclk);
        do bus(1'b0, 6'h18, 32'h0); while (q[0] !== 1'b0);
    endtask : idle
    task automatic res(input int ch);
        rc(6'h0C, hi_exp(ch, level));
        rc(6'h10, 40'(level[7:0]));
    endtask : res
    task automatic conclude();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude
    initial begin
        seed = 32'h8EDF71DB;
        {rst_n, avs_read, avs_write, conv_pin, timer2_ovf, stall, dma_waitrequest} = 7'h01;
        avs_address = 6'h00;
        avs_writedata = 32'h0;
        level = 12'h000;
        slow = 3'h0;
        errors = 0;
        comparisons = 0;
        cycles = 0;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        rc(6'h00, 40'h40);
        rc(6'h08, 40'h00808000);
        chk({cal_gain, cal_offset}, 40'h8080);
        chk(ext_ref_sel, 1'b1);
        wr(6'h1C, 32'hFF);
        rc(6'h1C, 40'h0);
        for (int i = 0; i < 10; i++) begin
            level <= 12'($random(seed));
            slow <= 3'(i % 3);
            wr(6'h00, 32'h80 | 32'(i % 4) << 4 | 32'(i % 4) << 2);
            wr(6'h04, 32'h10 | 32'(i));
            idle();
            chk(conv_power_on, 1'b1);
            res(i);
        end
        wr(6'h00, 32'h81);
        wr(6'h04, 32'h03);
        level <= 12'($random(seed));
        conv_pin <= 1'b1;
        repeat (4) @(posedge mclk);
        conv_pin <= 1'b0;
        idle();
        res(3);
        wr(6'h00, 32'hB2);
        wr(6'h04, 32'h07);
        for (int k = 0; k < 2; k++) begin
            level <= 12'($random(seed));
            timer2_ovf <= 1'b1;
            @(posedge mclk);
            timer2_ovf <= 1'b0;
            idle();
            res(7);
        end
        wr(6'h00, 32'hB0);
        wr(6'h04, 32'h22);
        repeat (200) @(posedge mclk);
        // New level mid-run; only repeated conversions can report it
        level <= 12'($random(seed));
        repeat (200) @(posedge mclk);
        bus(1'b0, 6'h18, 32'h0);
        // Busy drops for one cycle between conversions, so it is not compared
        chk(40'(q[3:1]), 40'h3);
        wr(6'h04, 32'h00);
        idle();
        res(2);
        // Top of the address space, so the pointer must wrap
        wr(6'h14, 32'hFFFFFC);
        stall <= 1'b1;
        wr(6'h04, 32'h85);
        repeat (600) @(posedge mclk);
        rc(6'h18, 40'hF);
        stall <= 1'b0;
        while (seen.size() < 6) @(posedge mclk);
        wr(6'h04, 32'h00);
        idle();
        repeat (60) @(posedge mclk);
        foreach (seen[k]) chk(seen[k], {24'(32'hFFFFFC + 2 * k), 4'h5, level});
        wr(6'h18, 32'h08);
        rc(6'h18, 40'h4);
        wr(6'h00, 32'h80);
        level <= 12'($random(seed));
        wr(6'h08, 32'h201001);
        // Calibration runs on the next conversion, so start one
        wr(6'h04, 32'h10);
        idle();
        chk({cal_gain, cal_offset}, {8'h20, 8'(8'h10 + level[7:0])});
        wr(6'h00, 32'h00);
        repeat (3) @(posedge mclk);
        chk(conv_power_on, 1'b0);
        chk(ext_ref_sel, 1'b0);
        conclude();
    end
endmodule : acc_conv_ctrl_tb
